/* logic/iras_pkg.sv */
// shared constants and types for the two-wire register access port
package iras_pkg;
    // bus address, fixed in silicon
    localparam logic [6:0] DEV_ADDR = 7'h2e;
    // direction bit values
    localparam logic RW_WRITE = 1'h0;
    localparam logic RW_READ = 1'h1;
    // register pointer limits
    localparam logic [9:0] PTR_RESET = 10'h000;
    localparam logic [9:0] PTR_MAX = 10'h3ff;
    localparam logic [9:0] PTR_STEP = 10'h001;
    // rising-edge counts within one byte
    localparam logic [3:0] BIT_DATA_END = 4'h8;
    localparam logic [3:0] BIT_ACK_END = 4'h9;
    // write byte phases after the bus address
    localparam logic [1:0] WPH_ADDR_HI = 2'h0;
    localparam logic [1:0] WPH_ADDR_LO = 2'h1;
    localparam logic [1:0] WPH_DATA_HI = 2'h2;
    localparam logic [1:0] WPH_DATA_LO = 2'h3;
    // host clock timing
    localparam int CLK_NS = 10;
    localparam int SCL_PERIOD_NS = 640;
    localparam int QTR_CYC_INT = SCL_PERIOD_NS / (4 * CLK_NS);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC_INT - 1);
    // device side states
    typedef enum logic [2:0] {
        IRAS_IDLE, IRAS_ADDR, IRAS_WRITE, IRAS_READ, IRAS_SKIP
    } iras_dev_st_t;
    // host side states
    typedef enum logic [1:0] {
        IRAS_H_IDLE, IRAS_H_START, IRAS_H_BYTE, IRAS_H_STOP
    } iras_host_st_t;
    // kind of byte the host is moving
    typedef enum logic [2:0] {
        IRAS_K_DEVW, IRAS_K_AHI, IRAS_K_ALO, IRAS_K_WHI,
        IRAS_K_WLO, IRAS_K_DEVR, IRAS_K_RHI, IRAS_K_RLO
    } iras_kind_t;
endpackage

/* logic/iras_if.sv */
// two-wire bus between host end and device end
`timescale 1ns/1ps
interface iras_if;
    logic scl;       // serial clock, driven push-pull by the host
    logic h_sda_o;   // host data out, pulls low only
    logic h_sda_oe;  // host data enable, high while host pulls
    logic d_sda_o;   // device data out, pulls low only
    logic d_sda_oe;  // device data enable, high while device pulls
    logic sda;       // resolved data line level

    // wired-and with pull-up: any enabled low driver wins
    assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

    modport host (output scl, output h_sda_o, output h_sda_oe, input sda);
    modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface

/* logic/iras_dev.sv */
// device end: serial target giving access to a 16-bit register space
// How it works
// - target only, never starts a transfer
// - answers only bus address 0101110
// - first byte is address then direction
// - matching address acknowledged low on ninth pulse
// - direction 0 writes, 1 reads
// - nine pulses per byte, ack last
// - data moves only while clock low
// - start and stop seen while clock high
// - stop returns idle, pointer to zero
// - two address bytes, low ten bits used
// - data byte high first, then low
// - pointer steps after each write, no wrap
// - writes past top address are discarded
// - master sends whole byte pairs
// - master ends write with stop or restart
// - master sets pointer, then restarts to read
// - read sends high byte then low byte
// - read advances pointer, master ends with nack
// - at top address read repeats last register
`timescale 1ns/1ps
module iras_dev (
    input wire logic clk,              // system clock
    input wire logic rstn,             // async reset, active low
    iras_if.dev bus,                   // two-wire bus
    output logic [9:0] reg_addr,       // register pointer
    output logic reg_wr,               // one-cycle write strobe
    output logic [15:0] reg_wdata,     // write data
    output logic reg_rd,               // one-cycle read strobe
    input wire logic [15:0] reg_rdata  // data at reg_addr, same clock
);
    iras_pkg::iras_dev_st_t st;
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_f;
    logic sda_f;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic [1:0] wphase;
    logic [7:0] whi;
    logic full;
    logic [7:0] tx;
    logic [15:0] rd_word;
    logic lo_next;
    logic sda_oe;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic data_end;
    logic ack_end;
    logic addr_hit;
    logic ptr_inc;
    logic rd_load;

    // three-stage synchronisers for both pins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_sy <= 3'h7;
            sda_sy <= 3'h7;
        end
        else
        begin
            scl_sy <= {scl_sy[1:0], bus.scl};
            sda_sy <= {sda_sy[1:0], bus.sda};
        end
    end

    // a level counts once stages two and three agree
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_f <= 1'h1;
            sda_f <= 1'h1;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end
        else
        begin
            if (scl_sy[2] == scl_sy[1])
                scl_f <= scl_sy[2];
            if (sda_sy[2] == sda_sy[1])
                sda_f <= sda_sy[2];
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // bus events from filtered levels
    always_comb
    begin
        scl_rise = scl_f & ~scl_q;
        scl_fall = ~scl_f & scl_q;
        start_det = scl_f & scl_q & sda_q & ~sda_f;
        stop_det = scl_f & scl_q & ~sda_q & sda_f;
        data_end = scl_fall & (bit_cnt == iras_pkg::BIT_DATA_END);
        ack_end = scl_fall & (bit_cnt == iras_pkg::BIT_ACK_END);
        addr_hit = (shift[7:1] == iras_pkg::DEV_ADDR);
        ptr_inc = reg_wr
            | ((st == iras_pkg::IRAS_READ) & scl_rise & (bit_cnt == iras_pkg::BIT_DATA_END)
            & ~lo_next);
        rd_load = ack_end & (((st == iras_pkg::IRAS_ADDR) & (rw == iras_pkg::RW_READ))
            | ((st == iras_pkg::IRAS_READ) & ~shift[0]));
    end

    // byte framing and transfer state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= iras_pkg::IRAS_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            rw <= 1'h0;
        end
        else if (start_det)
        begin
            st <= iras_pkg::IRAS_ADDR;
            bit_cnt <= 4'h0;
        end
        else if (stop_det)
        begin
            st <= iras_pkg::IRAS_IDLE;
            bit_cnt <= 4'h0;
        end
        else
        begin
            case (st)
                iras_pkg::IRAS_ADDR, iras_pkg::IRAS_WRITE, iras_pkg::IRAS_READ:
                begin
                    if (scl_rise)
                    begin
                        shift <= {shift[6:0], sda_f};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    if (data_end && st == iras_pkg::IRAS_ADDR)
                    begin
                        rw <= shift[0];
                        if (!addr_hit)
                            st <= iras_pkg::IRAS_SKIP;
                    end
                    if (ack_end)
                    begin
                        bit_cnt <= 4'h0;
                        if (st == iras_pkg::IRAS_ADDR)
                            st <= (rw == iras_pkg::RW_READ) ? iras_pkg::IRAS_READ
                                : iras_pkg::IRAS_WRITE;
                        else if (st == iras_pkg::IRAS_READ && shift[0])
                            st <= iras_pkg::IRAS_SKIP;
                    end
                end
                iras_pkg::IRAS_IDLE, iras_pkg::IRAS_SKIP:
                    bit_cnt <= 4'h0;
                default:
                    st <= iras_pkg::IRAS_IDLE;
            endcase
        end
    end

    // register pointer and write byte phase
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_addr <= iras_pkg::PTR_RESET;
            wphase <= iras_pkg::WPH_ADDR_HI;
            whi <= 8'h00;
            full <= 1'h0;
        end
        else if (stop_det)
        begin
            reg_addr <= iras_pkg::PTR_RESET;
            wphase <= iras_pkg::WPH_ADDR_HI;
            full <= 1'h0;
        end
        else if (start_det)
            wphase <= iras_pkg::WPH_ADDR_HI;
        else if (data_end && st == iras_pkg::IRAS_WRITE)
        begin
            case (wphase)
                iras_pkg::WPH_ADDR_HI:
                begin
                    reg_addr[9:8] <= shift[1:0];
                    full <= 1'h0;
                    wphase <= iras_pkg::WPH_ADDR_LO;
                end
                iras_pkg::WPH_ADDR_LO:
                begin
                    reg_addr[7:0] <= shift;
                    wphase <= iras_pkg::WPH_DATA_HI;
                end
                iras_pkg::WPH_DATA_HI:
                begin
                    whi <= shift;
                    wphase <= iras_pkg::WPH_DATA_LO;
                end
                default:
                    wphase <= iras_pkg::WPH_DATA_HI;
            endcase
        end
        else if (ptr_inc)
        begin
            // saturate: stay on the top register and flag it
            if (reg_addr == iras_pkg::PTR_MAX)
                full <= 1'h1;
            else
                reg_addr <= reg_addr + iras_pkg::PTR_STEP;
        end
    end

    // write strobe one cycle after the low data byte
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_wr <= 1'h0;
            reg_wdata <= 16'h0000;
        end
        else
        begin
            reg_wr <= data_end & (st == iras_pkg::IRAS_WRITE) & ~full & ~start_det & ~stop_det
                & (wphase == iras_pkg::WPH_DATA_LO);
            if (data_end && st == iras_pkg::IRAS_WRITE && wphase == iras_pkg::WPH_DATA_LO)
                reg_wdata <= {whi, shift};
        end
    end

    // data line drive: acks and read bits, changed only on clock fall
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sda_oe <= 1'h0;
            tx <= 8'h00;
            rd_word <= 16'h0000;
            lo_next <= 1'h0;
            reg_rd <= 1'h0;
        end
        else
        begin
            reg_rd <= 1'h0;
            if (start_det || stop_det)
            begin
                sda_oe <= 1'h0;
                lo_next <= 1'h0;
            end
            else if (data_end)
            begin
                // ack own address and every written byte; release for master ack
                sda_oe <= ((st == iras_pkg::IRAS_ADDR) & addr_hit)
                    | (st == iras_pkg::IRAS_WRITE);
            end
            else if (rd_load)
            begin
                if (lo_next)
                begin
                    sda_oe <= ~rd_word[7];
                    tx <= {rd_word[6:0], 1'h0};
                    lo_next <= 1'h0;
                end
                else
                begin
                    sda_oe <= ~reg_rdata[15];
                    tx <= {reg_rdata[14:8], 1'h0};
                    rd_word <= reg_rdata;
                    reg_rd <= 1'h1;
                    lo_next <= 1'h1;
                end
            end
            else if (ack_end)
                sda_oe <= 1'h0;
            else if (scl_fall && st == iras_pkg::IRAS_READ && bit_cnt != 4'h0)
            begin
                sda_oe <= ~tx[7];
                tx <= {tx[6:0], 1'h0};
            end
        end
    end

    assign bus.d_sda_oe = sda_oe;
    assign bus.d_sda_o = 1'h0; // open drain: only ever pulls low
endmodule

/* logic/iras_host.sv */
// host end: bus master that writes or reads runs of 16-bit registers
`timescale 1ns/1ps
module iras_host (
    input wire logic clk,              // system clock
    input wire logic rstn,             // async reset, active low
    iras_if.host bus,                  // two-wire bus
    input wire logic cmd_valid,        // command request
    output logic cmd_ready,            // idle, command accepted
    input wire logic cmd_rw,           // 0 write, 1 read
    input wire logic [9:0] cmd_addr,   // first register
    input wire logic [7:0] cmd_count,  // registers, 0 means 1
    input wire logic [15:0] wr_data,   // next word to write
    output logic wr_take,              // pulse: wr_data taken
    output logic [15:0] rd_data,       // word read
    output logic rd_valid,             // pulse: rd_data new
    output logic done,                 // pulse: stop sent
    output logic nack                  // no ack seen in last command
);
    iras_pkg::iras_host_st_t st;
    iras_pkg::iras_kind_t kind;
    logic [2:0] sda_sy;
    logic sda_f;
    logic [7:0] qcnt;
    logic [1:0] qi;
    logic tick;
    logic [3:0] bit_idx;
    logic [7:0] txb;
    logic [7:0] rxb;
    logic [7:0] rhi;
    logic [15:0] wword;
    logic [7:0] left;
    logic rw;
    logic [9:0] addr;
    logic scl;
    logic sda_oe;
    logic rx_kind;
    logic last;

    // data line synchroniser with agreement filter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sda_sy <= 3'h7;
            sda_f <= 1'h1;
        end
        else
        begin
            sda_sy <= {sda_sy[1:0], bus.sda};
            if (sda_sy[2] == sda_sy[1])
                sda_f <= sda_sy[2];
        end
    end

    // quarter-period divider for the serial clock
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            qcnt <= 8'h00;
        else if (st == iras_pkg::IRAS_H_IDLE || tick)
            qcnt <= 8'h00;
        else
            qcnt <= qcnt + 8'h01;
    end

    always_comb
    begin
        tick = (st != iras_pkg::IRAS_H_IDLE) & (qcnt == iras_pkg::QTR_LAST);
        rx_kind = (kind == iras_pkg::IRAS_K_RHI) | (kind == iras_pkg::IRAS_K_RLO);
        last = (left == 8'h01);
    end

    // transaction sequencer
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= iras_pkg::IRAS_H_IDLE;
            kind <= iras_pkg::IRAS_K_DEVW;
            qi <= 2'h0;
            bit_idx <= 4'h0;
            txb <= 8'h00;
            rxb <= 8'h00;
            rhi <= 8'h00;
            wword <= 16'h0000;
            left <= 8'h00;
            rw <= 1'h0;
            addr <= 10'h000;
            scl <= 1'h1;
            sda_oe <= 1'h0;
            cmd_ready <= 1'h1;
            wr_take <= 1'h0;
            rd_data <= 16'h0000;
            rd_valid <= 1'h0;
            done <= 1'h0;
            nack <= 1'h0;
        end
        else
        begin
            wr_take <= 1'h0;
            rd_valid <= 1'h0;
            done <= 1'h0;
            case (st)
                iras_pkg::IRAS_H_IDLE:
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_ready <= 1'h0;
                        rw <= cmd_rw;
                        addr <= cmd_addr;
                        left <= (cmd_count == 8'h00) ? 8'h01 : cmd_count;
                        nack <= 1'h0;
                        kind <= iras_pkg::IRAS_K_DEVW;
                        qi <= 2'h0;
                        st <= iras_pkg::IRAS_H_START;
                    end
                iras_pkg::IRAS_H_START:
                    if (tick)
                    begin
                        qi <= qi + 2'h1;
                        case (qi)
                            2'h0: sda_oe <= 1'h0;
                            2'h1: scl <= 1'h1;
                            2'h2: sda_oe <= 1'h1; // falling data, clock high
                            default:
                            begin
                                scl <= 1'h0;
                                bit_idx <= 4'h0;
                                st <= iras_pkg::IRAS_H_BYTE;
                                if (kind == iras_pkg::IRAS_K_ALO)
                                begin
                                    kind <= iras_pkg::IRAS_K_DEVR;
                                    txb <= {iras_pkg::DEV_ADDR, iras_pkg::RW_READ};
                                end
                                else
                                begin
                                    kind <= iras_pkg::IRAS_K_DEVW;
                                    txb <= {iras_pkg::DEV_ADDR, iras_pkg::RW_WRITE};
                                end
                            end
                        endcase
                    end
                iras_pkg::IRAS_H_BYTE:
                    if (tick)
                    begin
                        qi <= qi + 2'h1;
                        case (qi)
                            2'h0:
                                // set data while clock is low
                                if (bit_idx == iras_pkg::BIT_DATA_END)
                                    sda_oe <= rx_kind & ~(kind == iras_pkg::IRAS_K_RLO & last);
                                else
                                    sda_oe <= ~rx_kind & ~txb[7];
                            2'h1: scl <= 1'h1;
                            2'h2:
                                if (bit_idx != iras_pkg::BIT_DATA_END)
                                    rxb <= {rxb[6:0], sda_f};
                            default:
                            begin
                                scl <= 1'h0;
                                txb <= {txb[6:0], 1'h0};
                                bit_idx <= bit_idx + 4'h1;
                                if (bit_idx == iras_pkg::BIT_DATA_END)
                                begin
                                    bit_idx <= 4'h0;
                                    if (!rx_kind && sda_f)
                                    begin
                                        nack <= 1'h1;
                                        st <= iras_pkg::IRAS_H_STOP;
                                    end
                                    else
                                    begin
                                        case (kind)
                                            iras_pkg::IRAS_K_DEVW:
                                            begin
                                                kind <= iras_pkg::IRAS_K_AHI;
                                                txb <= {6'h00, addr[9:8]};
                                            end
                                            iras_pkg::IRAS_K_AHI:
                                            begin
                                                kind <= iras_pkg::IRAS_K_ALO;
                                                txb <= addr[7:0];
                                            end
                                            iras_pkg::IRAS_K_ALO:
                                                if (rw)
                                                    st <= iras_pkg::IRAS_H_START;
                                                else
                                                begin
                                                    kind <= iras_pkg::IRAS_K_WHI;
                                                    txb <= wr_data[15:8];
                                                    wword <= wr_data;
                                                    wr_take <= 1'h1;
                                                end
                                            iras_pkg::IRAS_K_WHI:
                                            begin
                                                kind <= iras_pkg::IRAS_K_WLO;
                                                txb <= wword[7:0];
                                            end
                                            iras_pkg::IRAS_K_WLO:
                                                if (last)
                                                    st <= iras_pkg::IRAS_H_STOP;
                                                else
                                                begin
                                                    left <= left - 8'h01;
                                                    kind <= iras_pkg::IRAS_K_WHI;
                                                    txb <= wr_data[15:8];
                                                    wword <= wr_data;
                                                    wr_take <= 1'h1;
                                                end
                                            iras_pkg::IRAS_K_DEVR:
                                                kind <= iras_pkg::IRAS_K_RHI;
                                            iras_pkg::IRAS_K_RHI:
                                            begin
                                                kind <= iras_pkg::IRAS_K_RLO;
                                                rhi <= rxb;
                                            end
                                            default:
                                            begin
                                                rd_data <= {rhi, rxb};
                                                rd_valid <= 1'h1;
                                                kind <= iras_pkg::IRAS_K_RHI;
                                                left <= left - 8'h01;
                                                if (last)
                                                    st <= iras_pkg::IRAS_H_STOP;
                                            end
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                iras_pkg::IRAS_H_STOP:
                    if (tick)
                    begin
                        qi <= qi + 2'h1;
                        case (qi)
                            2'h0: sda_oe <= 1'h1;
                            2'h1: scl <= 1'h1;
                            2'h2: sda_oe <= 1'h0; // rising data, clock high
                            default:
                            begin
                                done <= 1'h1;
                                cmd_ready <= 1'h1;
                                st <= iras_pkg::IRAS_H_IDLE;
                            end
                        endcase
                    end
                default:
                    st <= iras_pkg::IRAS_H_IDLE;
            endcase
        end
    end

    assign bus.scl = scl;
    assign bus.h_sda_oe = sda_oe;
    assign bus.h_sda_o = 1'h0; // open drain: only ever pulls low
endmodule

/* test/iras_properties.sv */
// concurrent checks on the two-wire bus between host and device ends
`timescale 1ns/1ps
module iras_properties (
    input wire logic clk,      // system clock
    input wire logic rstn,     // async reset, active low
    input wire logic scl,      // serial clock
    input wire logic h_sda_o,  // host data out
    input wire logic h_sda_oe, // host pull enable
    input wire logic d_sda_o,  // device data out
    input wire logic d_sda_oe, // device pull enable
    input wire logic sda       // resolved data line
);
    // all checks on the system clock, quiet in reset
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_pull_low_only: assert property (!(d_sda_oe && d_sda_o) && !(h_sda_oe && h_sda_o))
        else $error("data driven high");
    a_dev_edge_low: assert property ($changed(d_sda_oe) |-> !scl)
        else $error("device moved data with clock high");
    a_no_dev_start: assert property (scl && $fell(sda) |-> !d_sda_oe)
        else $error("device made a start");
    a_stop_release: assert property (scl && $rose(sda) |-> (scl && sda && !d_sda_oe) [*8])
        else $error("bus not idle after stop");
    a_no_clash: assert property (!(scl && h_sda_oe && d_sda_oe))
        else $error("both ends pull data with clock high");
    a_start_clocks: assert property (scl && $fell(sda) |-> ##[1:40] !scl)
        else $error("no clock after start");
    a_sda_hold: assert property ($rose(scl) |-> $stable(sda) [*8])
        else $error("data moved early in clock high");
    a_ack_bound: assert property ($rose(d_sda_oe) |-> ##[1:700] !d_sda_oe)
        else $error("device holds data low too long");
endmodule

/* test/tb_iras.sv */
// bench: host and device ends on one bus, register file behind the device
`timescale 1ns/1ps
module tb_iras;
    logic clk = 0, rstn = 0, cmd_valid = 0, cmd_rw = 0, cmd_ready, wr_take, rd_valid;
    logic done, nack, reg_wr, reg_rd;
    logic [9:0] cmd_addr = 0, reg_addr;
    logic [7:0] cmd_count = 0, takes = 0;
    logic [15:0] mem [1024], reg_wdata, rd_data, rq[$];
    int error_cnt = 0, samples_checked = 0, nwr = 0, nrd = 0;
    iras_if bus ();
    iras_host u_iras_host (.clk(clk), .rstn(rstn), .bus(bus.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
        .wr_data(w(takes)), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .done(done), .nack(nack));
    iras_dev u_iras_dev (.clk(clk), .rstn(rstn), .bus(bus.dev), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(mem[reg_addr]));
    iras_properties u_iras_properties (.clk(clk), .rstn(rstn), .scl(bus.scl),
        .h_sda_o(bus.h_sda_o), .h_sda_oe(bus.h_sda_oe), .d_sda_o(bus.d_sda_o),
        .d_sda_oe(bus.d_sda_oe), .sda(bus.sda));
    // word k of the write stream, bytes kept distinct
    function automatic logic [15:0] w(input logic [7:0] k);
        return {k ^ 8'h5a, k};
    endfunction
    // register file, write stream and read capture
    always @(posedge clk)
    begin
        if (wr_take) takes <= takes + 8'h01;
        if (reg_wr) mem[reg_addr] <= reg_wdata;
        if (reg_wr) nwr <= nwr + 1;
        if (reg_rd) nrd <= nrd + 1;
        if (rd_valid) rq.push_back(rd_data);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one host command, then wait for done and check no nack and the pointer back at zero
    task automatic run(input logic rw, input logic [9:0] a, input logic [7:0] n);
        int i;
        @(negedge clk);
        cmd_valid = 1;
        cmd_rw = rw;
        cmd_addr = a;
        cmd_count = n;
        @(negedge clk);
        cmd_valid = 0;
        for (i = 0; i < 30000 && done !== 1'b1; i++) @(negedge clk);
        if (i == 30000) error_cnt++;
        repeat (8) @(negedge clk);
        chk(16'(nack), 16'h0000);
        chk(16'(reg_addr), 16'h0000);
    endtask
    // three words at the top: last discarded, read repeats the top register
    task automatic t_top;
        logic [7:0] k;
        k = takes;
        nwr = 0;
        rq.delete();
        run(1'b0, 10'h3fe, 8'h03);
        chk(mem[10'h3fe], w(k));
        chk(mem[10'h3ff], w(k + 8'h01));
        chk(16'(nwr), 16'h0002);
        nrd = 0;
        run(1'b1, 10'h3fe, 8'h03);
        chk(16'(rq.size()), 16'h0003);
        chk(16'(nrd), 16'h0003);
        chk(rq[0], w(k));
        chk(rq[2], w(k + 8'h01));
    endtask
    // pair written low in the space, second word read back alone
    task automatic t_mid;
        logic [7:0] k;
        k = takes;
        rq.delete();
        run(1'b0, 10'h005, 8'h02);
        run(1'b1, 10'h006, 8'h01);
        chk(rq[0], w(k + 8'h01));
    endtask
    task automatic results;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // clock
    initial forever #5 clk = ~clk;
    // hang guard
    initial
    begin
        #500us;
        error_cnt++;
        results;
    end
    // main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        rstn = 1;
        repeat (8) @(negedge clk);
        t_top;
        t_mid;
        results;
    end
endmodule
